// >>> jldr_pkg.sv
// Constants, field layouts and shared functions of the lane deframer link.
// Assumes both ends run on one 25 MHz clk_sys and see the same package.
package jldr_pkg;

    localparam int NUM_LANES = 8;
    localparam int OCTETS_PER_WORD = 4;
    localparam int LINE_BITS_PER_OCTET = 10;
    localparam int DEMUX_RATIO = LINE_BITS_PER_OCTET * OCTETS_PER_WORD;
    localparam int WORD_W = 8 * OCTETS_PER_WORD;
    localparam int SAMPLE_W = 16;
    localparam int MAX_SLOTS = 2 * NUM_LANES;
    localparam logic [7:0] COMMA_CHAR = 8'hbc;
    localparam int CGS_WORDS = 4;
    localparam int RATE_FACTOR = 20;
    localparam int LANE_RATE_MIN_MBPS = 750;
    localparam int LANE_RATE_MAX_MBPS = 12500;

    // Register map
    localparam logic [11:0] RX_MODE_ADDR = 12'h110;
    localparam logic [11:0] RX_STATUS_ADDR = 12'h114;
    localparam logic [11:0] TX_CTRL_ADDR = 12'h000;
    localparam logic [11:0] TX_STATUS_ADDR = 12'h004;
    localparam logic [31:0] MODE_RESET = 32'h0000_0011;
    localparam int MODE_L_LSB = 0;
    localparam int MODE_I_LSB = 4;
    localparam int MODE_SCR_BIT = 8;
    localparam int MODE_EN_BIT = 9;
    localparam int MODE_RATE_LSB = 16;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic lanes_supported(logic [3:0] l);
        return l == 4'h1 || l == 4'h2 || l == 4'h3 || l == 4'h4 ||
            l == 4'h6 || l == 4'h8;
    endfunction

    function automatic logic [7:0] lane_mask(logic [3:0] l);
        return 8'((9'h001 << l) - 9'h001);
    endfunction

    function automatic logic [2:0] octets_per_frame(logic [3:0] l);
        case (l)
            4'h2, 4'h6: return 3'h2;
            4'h4, 4'h8: return 3'h1;
            default: return 3'h4;
        endcase
    endfunction

    function automatic logic [1:0] converter_count(logic [3:0] l,
        logic [3:0] interp);
        if (l == 4'h8 && interp == 4'h1)
            return 2'h1;
        return 2'h2;
    endfunction

    function automatic logic [2:0] samples_per_frame(logic [3:0] l,
        logic [1:0] m);
        case (l)
            4'h3, 4'h6: return 3'h3;
            4'h8: return (m == 2'h1) ? 3'h4 : 3'h2;
            default: return 3'h1;
        endcase
    endfunction

    function automatic logic rate_ok(logic [15:0] msps, logic [1:0] m,
        logic [3:0] l);
        int r;
        r = 0;
        if (l == 4'h0)
            return 1'b0;
        r = RATE_FACTOR * int'(msps) * int'(m) / int'(l);
        return r >= LANE_RATE_MIN_MBPS && r <= LANE_RATE_MAX_MBPS;
    endfunction

    // Place of frame octet g in the word set: {lane, octet position}
    function automatic logic [4:0] octet_place(int g, logic [3:0] l,
        logic [2:0] f);
        int fl;
        int fr;
        int r;
        fl = int'(l) * int'(f);
        if (fl == 0)
            return 5'h00;
        fr = g / fl;
        r = g % fl;
        return {3'(r / int'(f)), 2'(fr * int'(f) + r % int'(f))};
    endfunction

    function automatic logic [7:0] word_octet(logic [WORD_W-1:0] w,
        logic [1:0] p);
        return w[WORD_W-1-8*p -: 8];
    endfunction

    // Self-synchronous 1 + x^14 + x^15, MSB first; {state, data}
    function automatic logic [46:0] scramble_word(logic [14:0] st,
        logic [31:0] d);
        logic b;
        b = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            b = d[i] ^ st[13] ^ st[14];
            d[i] = b;
            st = {st[13:0], b};
        end
        return {st, d};
    endfunction

    function automatic logic [46:0] descramble_word(logic [14:0] st,
        logic [31:0] d);
        logic b;
        b = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            b = d[i];
            d[i] = b ^ st[13] ^ st[14];
            st = {st[13:0], b};
        end
        return {st, d};
    endfunction

endpackage

// >>> jldr_link_if.sv
// Link between the transmitter end and the deframer end.
// Assumes both ends share clk_sys; each lane word is one decoded 1:40 word.
`timescale 1ns/100ps
interface jldr_link_if;
    import jldr_pkg::*;
    logic [NUM_LANES-1:0][WORD_W-1:0] serial_lane_input;
    logic [NUM_LANES-1:0][OCTETS_PER_WORD-1:0] serial_lane_k;
    logic link_sync_request_out;
    modport rx (
        input serial_lane_input,
        input serial_lane_k,
        output link_sync_request_out
    );
    modport tx (
        output serial_lane_input,
        output serial_lane_k,
        input link_sync_request_out
    );
endinterface

// >>> jldr_deframer_rx.sv
// Receive end: lane sync, octet unpacking, descrambling, deskew, deframing.
// Assumes lane words arrive on clk_sys, oldest octet in the top byte.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps
module jldr_deframer_rx
    import jldr_pkg::*;
#(
    parameter int SKEW_DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Sample output
    output logic sample_valid,
    output logic [4:0] sample_count,
    output logic [MAX_SLOTS-1:0][SAMPLE_W-1:0] sample_data,
    // Link
    jldr_link_if.rx link
);

    typedef enum logic [1:0] {LS_HUNT, LS_READY, LS_DATA} jldr_lane_e;
    localparam int PW = $clog2(SKEW_DEPTH);

    logic [31:0] mode_r;
    logic reject_r;
    logic [31:0] reg_rdata_r;
    logic sync_req_r;
    jldr_lane_e lane_st_r [NUM_LANES];
    logic [2:0] cgs_cnt_r [NUM_LANES];
    logic [14:0] desc_st_r [NUM_LANES];
    logic [WORD_W-1:0] skew_buf_r [NUM_LANES][SKEW_DEPTH];
    logic [PW-1:0] wptr_r [NUM_LANES];
    logic [PW:0] fill_r [NUM_LANES];
    logic [PW-1:0] rptr_r;
    logic rd_run_r;
    logic sample_valid_r;
    logic [4:0] sample_count_r;
    logic [MAX_SLOTS-1:0][SAMPLE_W-1:0] sample_data_r;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    wire [3:0] cfg_l = mode_r[MODE_L_LSB +: 4];
    wire [3:0] cfg_interp = mode_r[MODE_I_LSB +: 4];
    wire cfg_scr = mode_r[MODE_SCR_BIT];
    wire [15:0] cfg_msps = mode_r[MODE_RATE_LSB +: 16];
    wire [1:0] cfg_m = converter_count(cfg_l, cfg_interp);
    wire [2:0] cfg_f = octets_per_frame(cfg_l);
    wire [2:0] cfg_s = samples_per_frame(cfg_l, cfg_m);
    wire cfg_rate_ok = rate_ok(cfg_msps, cfg_m, cfg_l);
    wire [NUM_LANES-1:0] lane_act = lane_mask(cfg_l);
    wire mode_wr = reg_write && reg_addr == RX_MODE_ADDR;
    wire mode_ok = lanes_supported(reg_wdata[MODE_L_LSB +: 4]);
    wire mode_take = mode_wr && mode_ok;

    ////////////////////////////////////////////////////////////////////////
    // Per-lane decode
    logic [NUM_LANES-1:0] all_comma;
    logic [NUM_LANES-1:0] any_k;
    logic [NUM_LANES-1:0] lane_wr;
    logic [NUM_LANES-1:0] lane_live;
    logic [NUM_LANES-1:0] lane_good;
    logic [NUM_LANES-1:0] fill_ne;
    logic [NUM_LANES-1:0] lane_full;
    logic [NUM_LANES-1:0] lane_ok_mask;
    logic [NUM_LANES-1:0] lane_data_mask;
    logic [WORD_W-1:0] lane_word [NUM_LANES];
    logic [WORD_W-1:0] rd_word [NUM_LANES];
    logic [14:0] desc_nxt [NUM_LANES];
    jldr_lane_e lane_st_nxt [NUM_LANES];
    logic [2:0] cgs_nxt [NUM_LANES];

    always_comb begin
        logic [46:0] dsc;
        dsc = '0;
        for (int l = 0; l < NUM_LANES; l++) begin
            all_comma[l] = 1'b1;
            for (int p = 0; p < OCTETS_PER_WORD; p++) begin
                if (!(link.serial_lane_k[l][p] && word_octet(
                    link.serial_lane_input[l], 2'(p)) == COMMA_CHAR))
                    all_comma[l] = 1'b0;
            end
            any_k[l] = |link.serial_lane_k[l];
            lane_wr[l] = lane_act[l] && !any_k[l] &&
                lane_st_r[l] != LS_HUNT;
            lane_live[l] = !lane_act[l] || lane_wr[l];
            lane_good[l] = lane_live[l] ||
                (lane_st_r[l] == LS_READY && all_comma[l]);
            dsc = descramble_word(desc_st_r[l], link.serial_lane_input[l]);
            desc_nxt[l] = dsc[46:32];
            lane_word[l] = cfg_scr ? dsc[31:0] :
                link.serial_lane_input[l];
            rd_word[l] = skew_buf_r[l][rptr_r];
            fill_ne[l] = !lane_act[l] || fill_r[l] != '0;
            lane_full[l] = lane_act[l] && lane_wr[l] &&
                fill_r[l] == (PW+1)'(SKEW_DEPTH);
            lane_ok_mask[l] = lane_act[l] && lane_st_r[l] != LS_HUNT;
            lane_data_mask[l] = lane_act[l] && lane_st_r[l] == LS_DATA;
        end
    end

    // Deskew: lanes start at different cycles, reading waits for all
    wire flush = !(&lane_good) || mode_take;
    wire rd_go = !flush && (&lane_live) && (rd_run_r || &fill_ne);
    wire skew_err = |lane_full && !rd_go;

    always_comb begin
        for (int l = 0; l < NUM_LANES; l++) begin
            lane_st_nxt[l] = lane_st_r[l];
            cgs_nxt[l] = cgs_cnt_r[l];
            case (lane_st_r[l])
                LS_HUNT: begin
                    if (!all_comma[l])
                        cgs_nxt[l] = 3'h0;
                    else if (cgs_cnt_r[l] == 3'(CGS_WORDS - 1)) begin
                        // Clear the count so a later hunt needs a full run
                        lane_st_nxt[l] = LS_READY;
                        cgs_nxt[l] = 3'h0;
                    end else
                        cgs_nxt[l] = cgs_cnt_r[l] + 3'h1;
                end
                LS_READY: begin
                    if (!any_k[l])
                        lane_st_nxt[l] = LS_DATA;
                    else if (!all_comma[l])
                        lane_st_nxt[l] = LS_HUNT;
                end
                LS_DATA: begin
                    if (any_k[l])
                        lane_st_nxt[l] = LS_HUNT;
                end
                default: lane_st_nxt[l] = LS_HUNT;
            endcase
            if (!lane_act[l] || mode_take || skew_err) begin
                lane_st_nxt[l] = LS_HUNT;
                cgs_nxt[l] = 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lane state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int l = 0; l < NUM_LANES; l++) begin
                lane_st_r[l] <= LS_HUNT;
                cgs_cnt_r[l] <= 3'h0;
                desc_st_r[l] <= 15'h0000;
            end
        end else begin
            for (int l = 0; l < NUM_LANES; l++) begin
                lane_st_r[l] <= lane_st_nxt[l];
                cgs_cnt_r[l] <= cgs_nxt[l];
                if (lane_wr[l])
                    desc_st_r[l] <= desc_nxt[l];
                else if (lane_st_r[l] != LS_DATA)
                    desc_st_r[l] <= 15'h0000;
            end
        end
    end

    // Skew buffer storage
    always_ff @(posedge clk_sys) begin
        for (int l = 0; l < NUM_LANES; l++) begin
            if (lane_wr[l])
                skew_buf_r[l][wptr_r[l]] <= lane_word[l];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int l = 0; l < NUM_LANES; l++) begin
                wptr_r[l] <= '0;
                fill_r[l] <= '0;
            end
            rptr_r <= '0;
            rd_run_r <= 1'b0;
        end else begin
            for (int l = 0; l < NUM_LANES; l++) begin
                wptr_r[l] <= flush ? '0 : wptr_r[l] + PW'(lane_wr[l]);
                fill_r[l] <= flush ? '0 :
                    fill_r[l] + (PW+1)'(lane_wr[l]) - (PW+1)'(rd_go);
            end
            rptr_r <= flush ? '0 : rptr_r + PW'(rd_go);
            rd_run_r <= !flush && (rd_run_r || rd_go);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transport: frame octets pair into 16-bit samples
    logic [MAX_SLOTS-1:0][SAMPLE_W-1:0] slot_data;

    always_comb begin
        logic [4:0] hp;
        logic [4:0] lp;
        hp = '0;
        lp = '0;
        slot_data = '0;
        for (int n = 0; n < MAX_SLOTS; n++) begin
            if (n < 2 * int'(cfg_l)) begin
                hp = octet_place(2 * n, cfg_l, cfg_f);
                lp = octet_place(2 * n + 1, cfg_l, cfg_f);
                slot_data[n] = {word_octet(rd_word[hp[4:2]], hp[1:0]),
                    word_octet(rd_word[lp[4:2]], lp[1:0])};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sample_valid_r <= 1'b0;
            sample_count_r <= 5'h00;
            sample_data_r <= '0;
        end else begin
            sample_valid_r <= rd_go;
            sample_count_r <= {cfg_l, 1'b0};
            if (rd_go)
                sample_data_r <= slot_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and sync request
    wire [31:0] status_word = {1'b0, cfg_s, 1'b0, cfg_f, 2'b00, cfg_m,
        1'b0, cfg_rate_ok, reject_r, rd_run_r, lane_data_mask,
        lane_ok_mask};

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_r <= MODE_RESET;
            reject_r <= 1'b0;
        end else if (mode_take) begin
            mode_r <= reg_wdata;
            reject_r <= 1'b0;
        end else if (mode_wr) begin
            reject_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            reg_rdata_r <= 32'h0000_0000;
        else if (reg_read && reg_addr == RX_MODE_ADDR)
            reg_rdata_r <= mode_r;
        else if (reg_read && reg_addr == RX_STATUS_ADDR)
            reg_rdata_r <= status_word;
        else
            reg_rdata_r <= 32'h0000_0000;
    end

    // One request covers all lanes of the link
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            sync_req_r <= 1'b1;
        else
            sync_req_r <= |(lane_act & ~lane_ok_mask);
    end

    assign link.link_sync_request_out = sync_req_r;
    assign reg_rdata = reg_rdata_r;
    assign sample_valid = sample_valid_r;
    assign sample_count = sample_count_r;
    assign sample_data = sample_data_r;

endmodule // jldr_deframer_rx

// >>> jldr_framer_tx.sv
// Transmit end: maps samples onto lanes, scrambles, answers sync requests.
// Assumes it shares clk_sys with the deframer end.
`timescale 1ns/100ps
module jldr_framer_tx
    import jldr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Sample input
    input wire logic tx_sample_valid,
    input wire logic [MAX_SLOTS-1:0][SAMPLE_W-1:0] tx_sample_data,
    output logic tx_sample_ready,
    // Link
    jldr_link_if.tx link
);

    typedef enum logic [1:0] {TX_OFF, TX_CGS, TX_DATA} jldr_tx_e;

    logic [31:0] ctrl_r;
    logic reject_r;
    logic [31:0] reg_rdata_r;
    logic ready_r;
    jldr_tx_e state_r;
    jldr_tx_e state_nxt;
    logic [14:0] scr_st_r [NUM_LANES];
    logic [NUM_LANES-1:0][WORD_W-1:0] lane_data_r;
    logic [NUM_LANES-1:0][OCTETS_PER_WORD-1:0] lane_k_r;

    wire [3:0] cfg_l = ctrl_r[MODE_L_LSB +: 4];
    wire [3:0] cfg_interp = ctrl_r[MODE_I_LSB +: 4];
    wire cfg_scr = ctrl_r[MODE_SCR_BIT];
    wire cfg_en = ctrl_r[MODE_EN_BIT];
    wire [1:0] cfg_m = converter_count(cfg_l, cfg_interp);
    wire [2:0] cfg_f = octets_per_frame(cfg_l);
    wire cfg_rate_ok = rate_ok(ctrl_r[MODE_RATE_LSB +: 16], cfg_m, cfg_l);
    wire [NUM_LANES-1:0] lane_act = lane_mask(cfg_l);
    wire ctrl_wr = reg_write && reg_addr == TX_CTRL_ADDR;
    wire ctrl_take = ctrl_wr && lanes_supported(reg_wdata[MODE_L_LSB +: 4]);
    wire sync_req = link.link_sync_request_out;
    wire emit_data = state_r == TX_DATA && !sync_req;
    wire take = tx_sample_valid && ready_r;

    ////////////////////////////////////////////////////////////////////////
    // Sample to lane mapping and scrambling
    logic [WORD_W-1:0] tx_word [NUM_LANES];
    logic [WORD_W-1:0] scr_out [NUM_LANES];
    logic [14:0] scr_nxt [NUM_LANES];

    always_comb begin
        logic [4:0] hp;
        logic [4:0] lp;
        logic [46:0] sc;
        hp = '0;
        lp = '0;
        sc = '0;
        for (int l = 0; l < NUM_LANES; l++)
            tx_word[l] = '0;
        for (int n = 0; n < MAX_SLOTS; n++) begin
            if (take && n < 2 * int'(cfg_l)) begin
                hp = octet_place(2 * n, cfg_l, cfg_f);
                lp = octet_place(2 * n + 1, cfg_l, cfg_f);
                tx_word[hp[4:2]][WORD_W-1-8*hp[1:0] -: 8] =
                    tx_sample_data[n][15:8];
                tx_word[lp[4:2]][WORD_W-1-8*lp[1:0] -: 8] =
                    tx_sample_data[n][7:0];
            end
        end
        for (int l = 0; l < NUM_LANES; l++) begin
            sc = scramble_word(scr_st_r[l], tx_word[l]);
            scr_nxt[l] = sc[46:32];
            scr_out[l] = cfg_scr ? sc[31:0] : tx_word[l];
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TX_OFF: begin
                if (cfg_en && cfg_rate_ok)
                    state_nxt = TX_CGS;
            end
            TX_CGS: begin
                if (!sync_req)
                    state_nxt = TX_DATA;
            end
            TX_DATA: begin
                if (sync_req)
                    state_nxt = TX_CGS;
            end
            default: state_nxt = TX_OFF;
        endcase
        if (!cfg_en || ctrl_take)
            state_nxt = TX_OFF;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= TX_OFF;
            ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ready_r <= state_nxt == TX_DATA;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lane_data_r <= '0;
            lane_k_r <= '0;
            for (int l = 0; l < NUM_LANES; l++)
                scr_st_r[l] <= 15'h0000;
        end else begin
            for (int l = 0; l < NUM_LANES; l++) begin
                scr_st_r[l] <= emit_data ? scr_nxt[l] : 15'h0000;
                if (!lane_act[l] || state_r == TX_OFF) begin
                    lane_data_r[l] <= '0;
                    lane_k_r[l] <= '0;
                end else if (emit_data) begin
                    lane_data_r[l] <= scr_out[l];
                    lane_k_r[l] <= '0;
                end else begin
                    lane_data_r[l] <= {OCTETS_PER_WORD{COMMA_CHAR}};
                    lane_k_r[l] <= '1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= MODE_RESET;
            reject_r <= 1'b0;
        end else if (ctrl_take) begin
            ctrl_r <= reg_wdata;
            reject_r <= 1'b0;
        end else if (ctrl_wr) begin
            reject_r <= 1'b1;
        end
    end

    wire [31:0] status_word = {27'h0, cfg_en, reject_r, cfg_rate_ok,
        state_r == TX_DATA, sync_req};

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            reg_rdata_r <= 32'h0000_0000;
        else if (reg_read && reg_addr == TX_CTRL_ADDR)
            reg_rdata_r <= ctrl_r;
        else if (reg_read && reg_addr == TX_STATUS_ADDR)
            reg_rdata_r <= status_word;
        else
            reg_rdata_r <= 32'h0000_0000;
    end

    assign link.serial_lane_input = lane_data_r;
    assign link.serial_lane_k = lane_k_r;
    assign reg_rdata = reg_rdata_r;
    assign tx_sample_ready = ready_r;

endmodule // jldr_framer_tx

// >>> jldr_link_props.sv
// Checker on the lane words and the sync request of the link.
// Assumes both ends share clk_sys; lane 0 is active in every mode.
`timescale 1ns/100ps
module jldr_link_props
    import jldr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Link
    input wire logic [NUM_LANES-1:0][WORD_W-1:0] serial_lane_input,
    input wire logic [NUM_LANES-1:0][OCTETS_PER_WORD-1:0] serial_lane_k,
    input wire logic link_sync_request_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire [3:0] k0 = serial_lane_k[0];
    wire [31:0] w0 = serial_lane_input[0];
    wire req = link_sync_request_out;
    wire cm = k0 == 4'hf && w0 == 32'hbcbcbcbc;
    wire dt = k0 == 4'h0 && w0 != 32'h0;
    logic [2:0] ncm_r;
    // Consecutive comma words on lane 0
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            ncm_r <= 3'h0;
        else if (!cm)
            ncm_r <= 3'h0;
        else if (ncm_r != 3'h7)
            ncm_r <= ncm_r + 3'h1;
    end
    ////////////////////////////////////////////////////////////////////
    a_req_on_reset: assert property ($rose(reset_n) |-> req)
        else $error("request low after reset");
    a_req_commas: assert property (req |=> cm || k0 == 4'h0)
        else $error("no commas while requested");
    a_ctrl_full: assert property (k0 != 4'h0 |-> cm)
        else $error("partial control word");
    a_loss_raises: assert property (k0 != 4'h0 && !cm |-> ##[1:2] req)
        else $error("sync loss not requested");
    a_drop_after_cgs: assert property
        ($fell(req) |-> $past(ncm_r) >= 3'h4)
        else $error("request dropped early");
    a_data_after_sync: assert property
        (dt |-> !$past(req) && !$past(req, 2))
        else $error("data while requested");
    a_sync_gap: assert property ($fell(req) |-> !dt ##1 !dt)
        else $error("data too soon");
    a_lanes_together: assert property
        (req |=> serial_lane_k[1] inside {4'h0, 4'hf})
        else $error("lane 1 not in step");
    c_lost: cover property ($rose(req));
    c_won: cover property ($fell(req));
    c_data: cover property (dt);
endmodule // jldr_link_props

// >>> jesd_lane_deframer_rx_tb_top.sv
// Bench joining both link ends; registers, samples and wire checked.
// Assumes the package, interface, both ends and the checker come first.
`timescale 1ns/100ps
module jesd_lane_deframer_rx_tb_top;
    import jldr_pkg::*;
    logic clk_sys = 1'h0, reset_n = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0, rd_rx, rd_tx;
    logic [MAX_SLOTS-1:0][SAMPLE_W-1:0] tx_d = '0, rx_d, last, q[$];
    logic tx_v = 1'h0, rdy, sv, tk = 1'h0, run = 1'h0;
    logic [4:0] cnt;
    int n_fail = 0, compares = 0, cyc = 0, cl = 1, cs = 0;
    jldr_link_if link();
    jldr_deframer_rx #(.SKEW_DEPTH(4)) u_jldr_deframer_rx(.clk_sys,
        .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata(rd_rx), .sample_valid(sv), .sample_count(cnt),
        .sample_data(rx_d), .link(link.rx));
    jldr_framer_tx u_jldr_framer_tx(.clk_sys, .reset_n, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata(rd_tx),
        .tx_sample_valid(tx_v), .tx_sample_data(tx_d),
        .tx_sample_ready(rdy), .link(link.tx));
    jldr_link_props u_jldr_link_props(.clk_sys, .reset_n,
        .serial_lane_input(link.serial_lane_input),
        .serial_lane_k(link.serial_lane_k),
        .link_sync_request_out(link.link_sync_request_out));
    always #20 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out;
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clk_sys);
        reg_write <= 1'h0;
    endtask
    task automatic rd(logic [11:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clk_sys);
        reg_read <= 1'h0;
        @(posedge clk_sys);
        d = rd_rx | rd_tx;
    endtask
    // Status fields S, F, M, rate good and link running
    function automatic logic [31:0] fld(int l, int i, int ok);
        int f, m, s;
        f = l == 2 || l == 6 ? 2 : l == 4 || l == 8 ? 1 : 4;
        m = l == 8 && i == 1 ? 1 : 2;
        s = l == 3 || l == 6 ? 3 : l != 8 ? 1 : m == 1 ? 4 : 2;
        return 32'(s << 28 | f << 24 | m << 20 | ok << 18 | ok << 16);
    endfunction
    // Octet h of slot n, taken from the lane that must carry it
    function automatic logic [7:0] ob(int n, int h);
        int f, g, p;
        f = int'(fld(cl, 2, 0) >> 24) & 7;
        g = 2 * n + h;
        p = g % (cl * f) / f * 4 + g / (cl * f) * f + g % f;
        return link.serial_lane_input[p / 4][31 - 8 * (p % 4) -: 8];
    endfunction
    always @(posedge clk_sys) begin
        cyc++;
        tx_v <= run && $urandom % 4 != 0;
        for (int n = 0; n < MAX_SLOTS; n++)
            tx_d[n] <= n == 0 ? 16'hbcbc : 16'($urandom);
        if (tk && cs == 0)
            for (int n = 0; n < 2 * cl; n++)
                chk({ob(n, 0), ob(n, 1)}, last[n]);
        tk <= rdy && !link.link_sync_request_out;
        last <= tx_v ? tx_d : '0;
        if (rdy && !link.link_sync_request_out)
            q.push_back(tx_v ? tx_d : '0);
        if (sv) begin
            chk(cnt, 2 * cl);
            chk(32'(q.size() != 0), 1);
            if (q.size() != 0) begin
                for (int n = 0; n < 2 * cl; n++)
                    chk(rx_d[n], q[0][n]);
                void'(q.pop_front());
            end
        end
        if (cyc == 6000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        logic [31:0] v;
        int ls[8] = '{1, 2, 3, 4, 6, 8, 8, 2};
        int is[8] = '{2, 2, 2, 2, 2, 2, 1, 2};
        void'($urandom(66892));
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'h1;
        rd(RX_STATUS_ADDR, v);
        chk(v & 32'h7737_0000, fld(1, 1, 0));
        rd(12'h7fc, v);
        chk(v, 0);
        for (int k = 0; k < 8; k++) begin
            v = 32'h012c_0000 | 32'(k == 7) << 8 | is[k] << 4 | ls[k];
            wr(RX_MODE_ADDR, v);
            wr(TX_CTRL_ADDR, v | 32'h200);
            repeat (4) @(negedge clk_sys);
            q.delete();
            cl = ls[k];
            cs = k == 7;
            for (int w = 0; w < 200 && link.link_sync_request_out; w++)
                @(posedge clk_sys);
            chk(link.link_sync_request_out, 0);
            run <= 1'h1;
            repeat (30) @(posedge clk_sys);
            // Tx restart mid-stream: commas in data must raise the request
            if (k == 3) begin
                wr(TX_CTRL_ADDR, v | 32'h200);
                repeat (5) @(posedge clk_sys);
                chk(link.link_sync_request_out, 1);
                q.delete();
                repeat (20) @(posedge clk_sys);
            end
            rd(RX_STATUS_ADDR, v);
            chk(v & 32'h7737_0000, fld(ls[k], is[k], 1));
            rd(TX_STATUS_ADDR, v);
            chk(v[4:1], 4'hb);
            run <= 1'h0;
        end
        wr(RX_MODE_ADDR, 32'h012c_0025);
        wr(TX_CTRL_ADDR, 32'h012c_0227);
        rd(RX_STATUS_ADDR, v);
        chk(v[17], 1);
        rd(TX_STATUS_ADDR, v);
        chk(v[3], 1);
        close_out();
    end
endmodule // jesd_lane_deframer_rx_tb_top
